/* hdl/scw_pkg.sv */
// Package of constants and types for the scan cycle watchdog.
`default_nettype none
package scw_pkg;
    localparam int CLK_FREQ_HZ = 250_000_000;
    localparam int TICK_MS_HZ = 1000;
    localparam int TICK_CYCLES = CLK_FREQ_HZ / TICK_MS_HZ;
    localparam logic [15:0] WDT_LIMIT_MAX = 16'h7FFF;
    localparam logic [15:0] WDT_LIMIT_RST = 16'h00C8;
    localparam logic [1:0] OFF_LIMIT = 2'h0;
    localparam logic [1:0] OFF_STATUS = 2'h1;
    localparam logic [1:0] OFF_MASK = 2'h2;
    localparam logic [1:0] OFF_STATE = 2'h3;
    localparam int ST_TIMEOUT = 0;
    localparam int ST_CALL_ERR = 1;
    localparam int ST_LOOP_ERR = 2;
    localparam int ST_SCAN_END = 3;
    localparam int ST_W = 4;
    localparam logic [7:0] DEPTH_W = 8'h08;
    typedef enum logic [4:0] {
        SCW_RUN = 5'h01,
        SCW_OUT_REF = 5'h02,
        SCW_IN_REF = 5'h04,
        SCW_WDT_REF = 5'h08,
        SCW_HALT = 5'h10
    } scw_state_t;
endpackage : scw_pkg
`default_nettype wire

/* hdl/scw_if.sv */
// Interface carrying nesting events between the top and the depth tracker.
`default_nettype none
interface scw_nest_if;
    logic call;
    logic ret;
    logic open;
    logic close;
    logic clr;
    logic call_busy;
    logic loop_busy;
    modport top (output call, ret, open, close, clr,
        input call_busy, loop_busy);
    modport trk (input call, ret, open, close, clr,
        output call_busy, loop_busy);
endinterface : scw_nest_if
`default_nettype wire

/* hdl/scw_nest.sv */
// Tracker of open subroutine calls and open loops.
`default_nettype none
module scw_nest
    import scw_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    scw_nest_if.trk nest
);
    logic [7:0] call_q;
    logic [7:0] loop_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            call_q <= 8'h00;
        end else if (ce) begin
            if (nest.clr) begin
                call_q <= 8'h00;
            end else if (nest.call && !nest.ret) begin
                call_q <= call_q + 8'h01;
            end else if (nest.ret && !nest.call && call_q != 8'h00) begin
                call_q <= call_q - 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            loop_q <= 8'h00;
        end else if (ce) begin
            if (nest.clr) begin
                loop_q <= 8'h00;
            end else if (nest.open && !nest.close) begin
                loop_q <= loop_q + 8'h01;
            end else if (nest.close && !nest.open && loop_q != 8'h00) begin
                loop_q <= loop_q - 8'h01;
            end
        end
    end

    assign nest.call_busy = (call_q != 8'h00);
    assign nest.loop_busy = (loop_q != 8'h00);
endmodule : scw_nest
`default_nettype wire

/* hdl/scw_top.sv */
// Scan cycle watchdog with scan end handling and register slave.
// Function
// - The scan time is measured from step zero until the main end runs.
// - A scan longer than the limit (200 ms by default) is a timeout error.
// - A timeout lights the CPU error indicator and halts execution.
// - The limit register holds ms units, up to 32767, reset to 200.
// - A new limit applies to all steps executed after the write.
// - Main end does output refresh, input refresh, watchdog refresh, step 0.
// - Refresh restarts timing; continuous form every time, pulse on rise.
// - Main end while a subroutine call is outstanding is an error.
// - Main end while a loop is open is an error.
`default_nettype none
module scw_top
    import scw_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    // Clock, reset and enable
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CE,
    // Instruction strobes from the sequencer
    input wire logic STEP0,
    input wire logic MAIN_END,
    input wire logic WDT_REF_EN,
    input wire logic WDT_REF_PULSE_EN,
    input wire logic CALL_INSTR,
    input wire logic SUBROUTINE_RETURN_INSTR_INSTR,
    input wire logic LOOP_OPEN,
    input wire logic LOOP_CLOSE,
    // Scan end sequencing towards the sequencer
    output logic OUT_REFRESH,
    output logic IN_REFRESH,
    output logic GOTO_STEP0,
    output logic EXEC_STATE,
    output logic CPU_ERR_LED,
    output logic IRQ,
    // Avalon-MM slave
    input wire logic [1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST
);
    // Refuse dividers that the 20-bit tick counter cannot serve.
    if (TICK_DIV < 1 || TICK_DIV > 1_000_000) begin : g_bad_div
        $error("TICK_DIV out of range");
    end

    scw_state_t state_q;
    logic [19:0] tick_cnt_q;
    logic tick_q;
    logic [15:0] ms_cnt_q;
    logic [15:0] limit_q;
    logic [ST_W-1:0] status_q;
    logic [ST_W-1:0] mask_q;
    logic pulse_prev_q;
    logic ack_q;
    logic refresh;
    logic scan_clr;
    logic timeout;
    logic bus_req;
    logic wr_take;
    logic [ST_W-1:0] events;
    scw_nest_if nest ();

    // Write strobe for one register word.
    function automatic logic wr_hit(input logic take, input logic [1:0] adr,
        input logic [1:0] off);
        return take && adr == off;
    endfunction : wr_hit

    scw_nest u_nest (
        .clk(CLK),
        .rst_n(RESET_N),
        .ce(CE),
        .nest(nest)
    );

    // Only accepted while running, so a halted controller stays frozen.
    assign nest.call = CALL_INSTR && state_q == SCW_RUN;
    assign nest.ret = SUBROUTINE_RETURN_INSTR_INSTR && state_q == SCW_RUN;
    assign nest.open = LOOP_OPEN && state_q == SCW_RUN;
    assign nest.close = LOOP_CLOSE && state_q == SCW_RUN;
    assign nest.clr = state_q == SCW_WDT_REF;

    // Continuous form each cycle while enabled, pulse form on the rise only.
    assign refresh = state_q == SCW_RUN && (WDT_REF_EN
        || (WDT_REF_PULSE_EN && !pulse_prev_q));
    assign scan_clr = refresh || state_q == SCW_WDT_REF
        || (state_q == SCW_RUN && STEP0);
    // Compare against the live limit so a rewrite acts at once.
    assign timeout = state_q == SCW_RUN && ms_cnt_q > limit_q;
    assign bus_req = (AVS_READ || AVS_WRITE) && !ack_q;
    // A write lands only at the edge where the master sees waitrequest low,
    // so the master and the registers agree on when it took effect.
    assign wr_take = AVS_WRITE && ack_q;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pulse_prev_q <= 1'b0;
        end else if (CE) begin
            pulse_prev_q <= WDT_REF_PULSE_EN;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tick_cnt_q <= 20'h00000;
            tick_q <= 1'b0;
        end else if (CE) begin
            tick_q <= 1'b0;
            if (scan_clr) begin
                tick_cnt_q <= 20'h00000;
            end else if (tick_cnt_q == 20'(TICK_DIV - 1)) begin
                tick_cnt_q <= 20'h00000;
                tick_q <= 1'b1;
            end else begin
                tick_cnt_q <= tick_cnt_q + 20'h00001;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ms_cnt_q <= 16'h0000;
        end else if (CE) begin
            if (scan_clr) begin
                ms_cnt_q <= 16'h0000;
            end else if (tick_q && ms_cnt_q != 16'hFFFF) begin
                ms_cnt_q <= ms_cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_q <= SCW_RUN;
        end else if (CE) begin
            unique case (state_q)
                SCW_RUN: begin
                    if (timeout) begin
                        state_q <= SCW_HALT;
                    end else if (MAIN_END) begin
                        state_q <= SCW_OUT_REF;
                    end
                end
                SCW_OUT_REF: state_q <= SCW_IN_REF;
                SCW_IN_REF: state_q <= SCW_WDT_REF;
                SCW_WDT_REF: state_q <= SCW_RUN;
                SCW_HALT: state_q <= SCW_HALT;
                default: state_q <= SCW_HALT;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            OUT_REFRESH <= 1'b0;
            IN_REFRESH <= 1'b0;
            GOTO_STEP0 <= 1'b0;
            EXEC_STATE <= 1'b1;
            CPU_ERR_LED <= 1'b0;
        end else if (CE) begin
            OUT_REFRESH <= state_q == SCW_RUN && MAIN_END && !timeout;
            IN_REFRESH <= state_q == SCW_OUT_REF;
            GOTO_STEP0 <= state_q == SCW_IN_REF;
            EXEC_STATE <= !(timeout || state_q == SCW_HALT);
            CPU_ERR_LED <= timeout || state_q == SCW_HALT;
        end
    end

    assign events[ST_TIMEOUT] = timeout;
    assign events[ST_CALL_ERR] = state_q == SCW_RUN && MAIN_END
        && nest.call_busy;
    assign events[ST_LOOP_ERR] = state_q == SCW_RUN && MAIN_END
        && nest.loop_busy;
    assign events[ST_SCAN_END] = state_q == SCW_WDT_REF;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            limit_q <= WDT_LIMIT_RST;
        end else if (CE && wr_hit(wr_take, AVS_ADDRESS, OFF_LIMIT)) begin
            limit_q <= AVS_WRITEDATA[15:0] > WDT_LIMIT_MAX
                ? WDT_LIMIT_MAX : AVS_WRITEDATA[15:0];
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mask_q <= '0;
        end else if (CE && wr_hit(wr_take, AVS_ADDRESS, OFF_MASK)) begin
            mask_q <= AVS_WRITEDATA[ST_W-1:0];
        end
    end

    // Set wins over a write-one clear in the same cycle.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            status_q <= '0;
        end else if (CE) begin
            if (wr_hit(wr_take, AVS_ADDRESS, OFF_STATUS)) begin
                status_q <= (status_q & ~AVS_WRITEDATA[ST_W-1:0]) | events;
            end else begin
                status_q <= status_q | events;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            IRQ <= 1'b0;
        end else if (CE) begin
            IRQ <= |(status_q & mask_q);
        end
    end

    // One wait cycle, then the answer with registered read data; writes
    // land in the answer cycle.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ack_q <= 1'b0;
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= 32'h00000000;
        end else if (CE) begin
            ack_q <= bus_req;
            AVS_WAITREQUEST <= !bus_req;
            if (bus_req && AVS_READ) begin
                unique case (AVS_ADDRESS)
                    OFF_LIMIT: AVS_READDATA <= {16'h0000, limit_q};
                    OFF_STATUS: AVS_READDATA <= {28'h0000000, status_q};
                    OFF_MASK: AVS_READDATA <= {28'h0000000, mask_q};
                    OFF_STATE: AVS_READDATA <= {11'h000, state_q, ms_cnt_q};
                endcase
            end
        end
    end
endmodule : scw_top
`default_nettype wire

/* test/scw_chk_sva.sv */
// Port level assertions for the scan cycle watchdog.
`default_nettype none
module scw_chk
    import scw_pkg::*;
#(
    parameter int TICK_DIV = 4
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Sequencer side
    input wire logic CE,
    input wire logic MAIN_END,
    input wire logic WDT_REF_EN,
    input wire logic OUT_REFRESH,
    input wire logic IN_REFRESH,
    input wire logic GOTO_STEP0,
    input wire logic EXEC_STATE,
    input wire logic CPU_ERR_LED,
    // Register bus
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic AVS_WAITREQUEST
);
    timeunit 1ns;
    timeprecision 1ps;
    logic end_busy;
    assign end_busy = OUT_REFRESH | IN_REFRESH | GOTO_STEP0;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    sequence s_end;
        OUT_REFRESH ##1 IN_REFRESH ##1 GOTO_STEP0;
    endsequence
    AST_END_SEQ: assert property (MAIN_END && CE && EXEC_STATE && !end_busy
        |=> s_end) else $error("Scan end steps out of order.");
    AST_OUT_CAUSE: assert property (OUT_REFRESH |-> $past(MAIN_END))
        else $error("Output refresh without main end.");
    AST_LED_HOLD: assert property (CPU_ERR_LED |=> CPU_ERR_LED)
        else $error("Error indicator dropped.");
    AST_LED_HALT: assert property (CPU_ERR_LED |-> !EXEC_STATE)
        else $error("Running with error indicator lit.");
    AST_HALT_HOLD: assert property (!EXEC_STATE |=> !EXEC_STATE)
        else $error("Halted controller resumed.");
    AST_REF_SAFE: assert property (WDT_REF_EN && CE && EXEC_STATE
        |=> !$rose(CPU_ERR_LED)) else $error("Timeout after refresh.");
    AST_WAIT_ANS: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
        |=> !AVS_WAITREQUEST) else $error("Bus answer late.");
    AST_WAIT_ONE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("Bus answer too long.");
endmodule : scw_chk
bind scw_top scw_chk #(.TICK_DIV(TICK_DIV)) chk_u (.*);
`default_nettype wire

/* test/scw_seq_model.sv */
// Behavioural program sequencer that issues instruction strobes.
`default_nettype none
module scw_seq_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Commands and scan end
    input wire logic [2:0] cmd,
    input wire logic goto_step0,
    // Strobes towards the watchdog
    output logic main_end,
    output logic [3:0] nest,
    output logic step0
);
    timeunit 1ns;
    timeprecision 1ps;
    // Strobes are registered so they change just after an edge.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            main_end <= 1'b0;
            nest <= 4'h0;
            step0 <= 1'b0;
        end else begin
            main_end <= (cmd == 3'h1);
            nest <= (cmd > 3'h1) ? 4'h1 << (cmd - 3'h2) : 4'h0;
            step0 <= goto_step0;
        end
    end
endmodule : scw_seq_model
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the scan cycle watchdog.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import scw_pkg::*;
    logic clk = 1'b0;
    logic ce = 1'b1;
    logic rst_n = 1'b0;
    logic ref_c = 1'b0;
    logic ref_p = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [1:0] adr = 2'h0;
    logic [31:0] wd = 32'h0;
    logic [2:0] cmd = 3'h0;
    logic [31:0] rdata, q;
    logic [3:0] nest;
    logic m_end, step0, out_r, in_r, go0, exec, led, irq, wreq;
    int num_errors = 0;
    int num_checks = 0;
    initial begin
        forever #2 clk = ~clk;
    end
    scw_seq_model seq_u (.clk(clk), .rst_n(rst_n), .cmd(cmd),
        .goto_step0(go0), .main_end(m_end), .nest(nest), .step0(step0));
    scw_top #(.TICK_DIV(4)) dut_u (.CLK(clk), .RESET_N(rst_n), .CE(ce),
        .STEP0(step0), .MAIN_END(m_end), .WDT_REF_EN(ref_c),
        .WDT_REF_PULSE_EN(ref_p), .CALL_INSTR(nest[0]),
        .SUBROUTINE_RETURN_INSTR_INSTR(nest[1]), .LOOP_OPEN(nest[2]), .LOOP_CLOSE(nest[3]),
        .OUT_REFRESH(out_r), .IN_REFRESH(in_r), .GOTO_STEP0(go0),
        .EXEC_STATE(exec), .CPU_ERR_LED(led), .IRQ(irq),
        .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wd), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // The request stays up until waitrequest is seen low at an edge.
    task bus(input logic w, input logic [1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 50) num_errors++;
    endtask : bus
    // Gaps of eight cycles keep main end strobes well apart.
    task op(input logic [2:0] c);
        @(posedge clk);
        cmd <= c;
        @(posedge clk);
        cmd <= 3'h0;
        repeat (6) @(posedge clk);
    endtask : op
    task close_out;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    initial begin
        #20000;
        num_errors++;
        close_out;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, OFF_LIMIT, 32'h0);
        chk(q, 32'h0000_00C8);
        bus(1'b1, OFF_LIMIT, 32'h0000_FFFF);
        bus(1'b0, OFF_LIMIT, 32'h0);
        chk(q, 32'h0000_7FFF);
        op(3'h2);
        op(3'h4);
        op(3'h1);
        bus(1'b0, OFF_STATUS, 32'h0);
        chk(q, 32'h0000_000E);
        bus(1'b1, OFF_MASK, 32'h0000_0008);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, OFF_STATUS, 32'h0000_000E);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        op(3'h2);
        op(3'h3);
        op(3'h4);
        op(3'h5);
        op(3'h1);
        bus(1'b0, OFF_STATUS, 32'h0);
        chk(q, 32'h0000_0008);
        bus(1'b1, OFF_STATUS, 32'h0000_0008);
        ref_c <= 1'b1;
        bus(1'b1, OFF_LIMIT, 32'h0000_0005);
        repeat (60) @(posedge clk);
        bus(1'b0, OFF_STATE, 32'h0);
        chk(q, 32'h0001_0000);
        chk({31'h0, exec}, 32'h1);
        // With the enable low nothing may count, so no timeout can occur.
        ref_c <= 1'b0;
        ce <= 1'b0;
        repeat (40) @(posedge clk);
        chk({31'h0, led}, 32'h0);
        // A held pulse condition refreshes once, so a timeout must follow.
        ce <= 1'b1;
        ref_p <= 1'b1;
        repeat (60) @(posedge clk);
        chk({31'h0, led}, 32'h1);
        chk({31'h0, exec}, 32'h0);
        bus(1'b1, OFF_MASK, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b0, OFF_STATUS, 32'h0);
        chk({31'h0, q[0]}, 32'h1);
        close_out;
    end
endmodule : testbench
`default_nettype wire
